// File: hw/pife_pkg.sv
/*
 * Constants, field layout and state encoding for the two-channel
 * particle image front end.
 * Assumes a single 50 MHz core clock and a synchronous active-high reset.
 */

package pife_pkg;

    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    localparam int CORE_CLK_HZ = 50_000_000;
    localparam int SLICE_HZ_MAX = 18_000_000;
    localparam int SLICE_DIV = 5;
    localparam logic [2:0] SLICE_DIV_LAST = 3'h4;

    // ------------------------------------------------------------------
    // Image and entry layout
    // ------------------------------------------------------------------
    localparam int PIX_W = 128;
    localparam int QUAD_W = 32;
    localparam int QUADS = 4;
    localparam int ENTRY_W = 36;
    localparam int CNT_W = 32;
    localparam int ENT_KIND_BIT = 35;
    localparam int ENT_FIRST_BIT = 34;
    localparam int ENT_QUAD_HI = 33;
    localparam int ENT_QUAD_LO = 32;
    localparam logic [ENTRY_W-1:0] NULL_ENTRY = 36'h7_0000_0000;

    // ------------------------------------------------------------------
    // Buffering
    // ------------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam logic [FIFO_AW:0] FIFO_FULL_LVL = 5'h10;
    localparam logic [FIFO_AW:0] FIFO_AFULL_LVL = 5'h0c;
    localparam int SKID_DEPTH = 2;
    localparam logic [1:0] SKID_FULL = 2'h2;

    // ------------------------------------------------------------------
    // Host register map and tag register fields
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_HORIZ_TAG = 3'h0;
    localparam logic [2:0] ADDR_HORIZ_UPPER = 3'h1;
    localparam logic [2:0] ADDR_HORIZ_LOWER = 3'h2;
    localparam logic [2:0] ADDR_VERT_TAG = 3'h3;
    localparam logic [2:0] ADDR_VERT_UPPER = 3'h4;
    localparam logic [2:0] ADDR_VERT_LOWER = 3'h5;
    localparam int TAG_KIND_BIT = 15;
    localparam int TAG_EMPTY_BIT = 14;
    localparam int TAG_NULL_BIT = 13;
    localparam int TAG_QUAD_HI = 6;
    localparam int TAG_QUAD_LO = 5;
    localparam int TAG_FIRST_BIT = 0;

    // ------------------------------------------------------------------
    // Writer states, Gray coded along sample, emit, close, overload
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PIFE_SAMPLE = 3'h0,
        PIFE_EMIT = 3'h1,
        PIFE_CLOSE = 3'h3,
        PIFE_OVLD = 3'h2,
        PIFE_REOPEN = 3'h6
    } pife_state_t;

endpackage : pife_pkg

// File: hw/pife_top.sv
/*
 * Two-channel particle image front end: per-channel slice quadrant writer
 * with pixel mask, slice counter, overload handling and linked mode, a
 * two-entry skid buffer and entry FIFO, and the host entry read port.
 * Assumes pixel vectors, masks and host strobes are synchronous to core_clk.
 */
// Behaviour
// - Writer runs at five clocks per slice
// - Accept two 128-bit vectors per slice
// - Mask forces stuck pixels inactive
// - Write only non-empty quadrants, with tags
// - Free-running 32-bit counter per slice, wrapping
// - Timing entry written at particle end
// - Almost full: finish slice, close, overload
// - Overload: no image data, counter runs, until empty
// - Leaving overload writes timing entry, resumes
// - Image entry bit layout
// - Timing entry bit layout
// - Linked: channel writes when either sees particle
// - Linked: empty channel writes null slice entry
// - Linked: shared overload entry and exit
// - One link control line, fully linked
// - Tag read fetches and holds one entry
// - Tag shows null slice flag
// - Tag register bit layout
// - Six host addresses, horizontal then vertical
// - Linked triggers force blank slices

`timescale 1ns/1ps
`default_nettype none

module pife_top
    import pife_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Image vectors and pixel masks, mask bit high removes the pixel
    input wire logic [PIX_W-1:0] horiz_pixels,
    input wire logic [PIX_W-1:0] vert_pixels,
    input wire logic [PIX_W-1:0] horiz_pixel_mask,
    input wire logic [PIX_W-1:0] vert_pixel_mask,
    // Link control
    input wire logic link_enable,
    // Host read port
    input wire logic [2:0] host_addr,
    input wire logic host_rd,
    output logic [15:0] host_rdata
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        pife_state_t st;
        logic [QUADS-1:0] quad_pend;
        logic [PIX_W-1:0] slice;
        logic first;
        logic in_part;
        logic null_pend;
        logic ovl_after;
        logic [CNT_W-1:0] tcount;
        logic [SKID_DEPTH-1:0][ENTRY_W-1:0] skid;
        logic [1:0] skid_n;
        logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] mem;
        logic [FIFO_AW-1:0] wp;
        logic [FIFO_AW-1:0] rp;
        logic [FIFO_AW:0] fn;
        logic [ENTRY_W-1:0] hold;
        logic hold_empty;
        logic hold_null;
    } pife_chan_t;

    typedef struct packed {
        logic [2:0] div;
        pife_chan_t [1:0] ch;
        logic [15:0] rdata;
    } pife_state_s_t;

    pife_state_s_t q;
    pife_state_s_t d;

    logic slice_en;
    logic [1:0][PIX_W-1:0] qual;
    logic [1:0] hit;
    logic [1:0] afull;
    logic [1:0] drained;

    function automatic logic [1:0] pife_lowest_quad(
        input logic [QUADS-1:0] pend
    );
        logic [1:0] sel;
        sel = 2'h0;
        for (int k = QUADS - 1; k >= 0; k--) begin
            if (pend[k]) begin
                sel = k[1:0];
            end
        end
        return sel;
    endfunction : pife_lowest_quad

    // ------------------------------------------------------------------
    // Slice enable, qualified pixels and shared channel status
    // ------------------------------------------------------------------
    always_comb begin
        slice_en = (q.div == SLICE_DIV_LAST);
        qual[0] = horiz_pixels & ~horiz_pixel_mask;
        qual[1] = vert_pixels & ~vert_pixel_mask;
        for (int c = 0; c < 2; c++) begin
            hit[c] = |qual[c];
            afull[c] = (q.ch[c].fn >= FIFO_AFULL_LVL);
            drained[c] = (q.ch[c].fn == '0) && (q.ch[c].skid_n == 2'h0);
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic push_v;
        logic [ENTRY_W-1:0] push_e;
        logic pop_v;
        logic take_v;
        logic skid_rdy;
        logic any_af;
        logic all_dr;
        logic other_hit;
        logic [1:0] qs;
        logic [1:0] n;
        logic [QUADS-1:0] pend;
        logic [FIFO_AW:0] fn;
        logic [2:0] tag_addr;
        push_v = 1'b0;
        push_e = '0;
        pop_v = 1'b0;
        take_v = 1'b0;
        skid_rdy = 1'b0;
        any_af = 1'b0;
        all_dr = 1'b0;
        other_hit = 1'b0;
        qs = 2'h0;
        n = 2'h0;
        pend = '0;
        fn = '0;
        tag_addr = 3'h0;
        d = q;
        if (slice_en) begin
            d.div = 3'h0;
        end else begin
            d.div = q.div + 3'h1;
        end

        for (int c = 0; c < 2; c++) begin
            push_v = 1'b0;
            push_e = '0;
            skid_rdy = (q.ch[c].skid_n != SKID_FULL);
            // Linked mode shares particle presence and FIFO status
            other_hit = link_enable & hit[1-c];
            any_af = afull[c] | (link_enable & afull[1-c]);
            all_dr = drained[c] & (~link_enable | drained[1-c]);
            if (slice_en) begin
                d.ch[c].tcount = q.ch[c].tcount + 32'h0000_0001;
            end

            // --------------------------------------------------------------
            // Writer: sample, emit quadrants, close, overload, reopen
            // --------------------------------------------------------------
            unique case (q.ch[c].st)
                PIFE_SAMPLE: begin
                    if (slice_en) begin
                        if (any_af) begin
                            d.ch[c].st = PIFE_CLOSE;
                            d.ch[c].ovl_after = 1'b1;
                            d.ch[c].in_part = 1'b0;
                        end else if (hit[c]) begin
                            d.ch[c].slice = qual[c];
                            for (int k = 0; k < QUADS; k++) begin
                                d.ch[c].quad_pend[k] =
                                    |qual[c][k*QUAD_W +: QUAD_W];
                            end
                            d.ch[c].first = 1'b1;
                            d.ch[c].in_part = 1'b1;
                            d.ch[c].st = PIFE_EMIT;
                        end else if (other_hit) begin
                            d.ch[c].null_pend = 1'b1;
                            d.ch[c].in_part = 1'b1;
                            d.ch[c].st = PIFE_EMIT;
                        end else if (q.ch[c].in_part) begin
                            d.ch[c].in_part = 1'b0;
                            d.ch[c].st = PIFE_CLOSE;
                        end
                    end
                end
                PIFE_EMIT: begin
                    if (skid_rdy) begin
                        push_v = 1'b1;
                        if (q.ch[c].null_pend) begin
                            push_e = NULL_ENTRY;
                            d.ch[c].null_pend = 1'b0;
                            d.ch[c].st = PIFE_SAMPLE;
                        end else begin
                            qs = pife_lowest_quad(q.ch[c].quad_pend);
                            push_e = {1'b0, q.ch[c].first, qs,
                                q.ch[c].slice[qs*QUAD_W +: QUAD_W]};
                            pend = q.ch[c].quad_pend;
                            pend[qs] = 1'b0;
                            d.ch[c].quad_pend = pend;
                            d.ch[c].first = 1'b0;
                            if (pend == '0) begin
                                d.ch[c].st = PIFE_SAMPLE;
                            end
                        end
                    end
                end
                PIFE_CLOSE: begin
                    if (skid_rdy) begin
                        push_v = 1'b1;
                        push_e = {1'b1, 1'b0, 2'h0, q.ch[c].tcount};
                        d.ch[c].ovl_after = 1'b0;
                        if (q.ch[c].ovl_after) begin
                            d.ch[c].st = PIFE_OVLD;
                        end else begin
                            d.ch[c].st = PIFE_SAMPLE;
                        end
                    end
                end
                PIFE_OVLD: begin
                    if (all_dr) begin
                        d.ch[c].st = PIFE_REOPEN;
                    end
                end
                PIFE_REOPEN: begin
                    if (skid_rdy) begin
                        push_v = 1'b1;
                        push_e = {1'b1, 1'b1, 2'h0, q.ch[c].tcount};
                        d.ch[c].st = PIFE_SAMPLE;
                    end
                end
                default: begin
                    // Unused codes fall back to sampling
                    d.ch[c].st = PIFE_SAMPLE;
                end
            endcase

            // --------------------------------------------------------------
            // Skid buffer: head drains into the FIFO, writer appends
            // --------------------------------------------------------------
            pop_v = (q.ch[c].skid_n != 2'h0) && (q.ch[c].fn != FIFO_FULL_LVL);
            n = q.ch[c].skid_n;
            if (pop_v) begin
                d.ch[c].mem[q.ch[c].wp] = q.ch[c].skid[0];
                d.ch[c].wp = q.ch[c].wp + 4'h1;
                d.ch[c].skid[0] = q.ch[c].skid[1];
                n = n - 2'h1;
            end
            if (push_v) begin
                d.ch[c].skid[n[0]] = push_e;
                n = n + 2'h1;
            end
            d.ch[c].skid_n = n;

            // --------------------------------------------------------------
            // Host tag read fetches one entry from the FIFO
            // --------------------------------------------------------------
            tag_addr = (c == 0) ? ADDR_HORIZ_TAG : ADDR_VERT_TAG;
            take_v = host_rd && (host_addr == tag_addr);
            fn = q.ch[c].fn;
            if (pop_v) begin
                fn = fn + 5'h01;
            end
            if (take_v) begin
                if (q.ch[c].fn != '0) begin
                    d.ch[c].hold = q.ch[c].mem[q.ch[c].rp];
                    d.ch[c].hold_empty = 1'b0;
                    d.ch[c].hold_null =
                        (q.ch[c].mem[q.ch[c].rp] == NULL_ENTRY);
                    d.ch[c].rp = q.ch[c].rp + 4'h1;
                    fn = fn - 5'h01;
                end else begin
                    d.ch[c].hold = '0;
                    d.ch[c].hold_empty = 1'b1;
                    d.ch[c].hold_null = 1'b0;
                end
            end
            d.ch[c].fn = fn;
        end

        // --------------------------------------------------------------
        // Read data reflects the entry held after this access
        // --------------------------------------------------------------
        if (host_rd) begin
            unique case (host_addr)
                ADDR_HORIZ_TAG, ADDR_VERT_TAG: begin
                    d.rdata = '0;
                    for (int c = 0; c < 2; c++) begin
                        if (host_addr == ((c == 0) ? ADDR_HORIZ_TAG
                                                   : ADDR_VERT_TAG)) begin
                            d.rdata[TAG_KIND_BIT] =
                                d.ch[c].hold[ENT_KIND_BIT];
                            d.rdata[TAG_EMPTY_BIT] = d.ch[c].hold_empty;
                            d.rdata[TAG_NULL_BIT] = d.ch[c].hold_null;
                            d.rdata[TAG_QUAD_HI:TAG_QUAD_LO] =
                                d.ch[c].hold[ENT_QUAD_HI:ENT_QUAD_LO];
                            d.rdata[TAG_FIRST_BIT] =
                                d.ch[c].hold[ENT_FIRST_BIT];
                        end
                    end
                end
                ADDR_HORIZ_UPPER: begin
                    d.rdata = q.ch[0].hold[31:16];
                end
                ADDR_HORIZ_LOWER: begin
                    d.rdata = q.ch[0].hold[15:0];
                end
                ADDR_VERT_UPPER: begin
                    d.rdata = q.ch[1].hold[31:16];
                end
                ADDR_VERT_LOWER: begin
                    d.rdata = q.ch[1].hold[15:0];
                end
                default: d.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign host_rdata = q.rdata;

endmodule : pife_top

`default_nettype wire

// File: testbench/pife_top_sva.sv
/* Checker for the pife_top host read port.
   Bound to pife_top; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module pife_top_chk
    import pife_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pixel side
    input wire logic [PIX_W-1:0] horiz_pixels,
    input wire logic [PIX_W-1:0] vert_pixels,
    input wire logic [PIX_W-1:0] horiz_pixel_mask,
    input wire logic [PIX_W-1:0] vert_pixel_mask,
    input wire logic link_enable,
    // Host port
    input wire logic [2:0] host_addr,
    input wire logic host_rd,
    input wire logic [15:0] host_rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic tag_rd;
    assign tag_rd = host_rd && (host_addr == ADDR_HORIZ_TAG
        || host_addr == ADDR_VERT_TAG);
    a_unmapped_zero: assert property (
        host_rd && host_addr > 3'h5 |=> host_rdata == 16'h0000)
        else $error("unmapped read returned data");
    a_rdata_holds: assert property (
        !host_rd |=> $stable(host_rdata))
        else $error("read data changed without a read");
    a_tag_spare_zero: assert property (
        tag_rd |=> host_rdata[12:7] == 6'h00 && host_rdata[4:1] == 4'h0)
        else $error("spare tag bits set");
    a_empty_tag_alone: assert property (
        tag_rd ##1 host_rdata[14] |-> host_rdata == 16'h4000)
        else $error("empty tag carries other bits");
    a_null_tag_form: assert property (
        tag_rd ##1 host_rdata[13] |-> host_rdata == 16'h2061)
        else $error("null slice tag malformed");
    a_timing_tag_form: assert property (
        tag_rd ##1 host_rdata[15] |-> host_rdata[14:1] == 14'h0000)
        else $error("timing tag malformed");
    a_empty_clears: assert property (
        (host_rd && host_addr == ADDR_HORIZ_TAG)
        ##1 (host_rdata[14] && !host_rd)[*3]
        ##1 (host_rd && host_addr == ADDR_HORIZ_UPPER)
        |=> host_rdata == 16'h0000)
        else $error("word after empty tag not zero");
    a_null_words_zero: assert property (
        (host_rd && host_addr == ADDR_VERT_TAG)
        ##1 (host_rdata[13] && !host_rd)[*3]
        ##1 (host_rd && host_addr == ADDR_VERT_UPPER)
        |=> host_rdata == 16'h0000)
        else $error("null slice data not zero");
endmodule : pife_top_chk
bind pife_top pife_top_chk i_chk (.core_clk(core_clk), .rst(rst),
    .horiz_pixels(horiz_pixels), .vert_pixels(vert_pixels),
    .horiz_pixel_mask(horiz_pixel_mask),
    .vert_pixel_mask(vert_pixel_mask), .link_enable(link_enable),
    .host_addr(host_addr), .host_rd(host_rd), .host_rdata(host_rdata));
`default_nettype wire

// File: testbench/pife_host_model.sv
/* Host processor model: one-cycle read strobe per request, data back.
   Assumes the one-cycle read latency of pife_top. */
`timescale 1ns/1ps
`default_nettype none
module pife_host_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bench side
    input wire logic req,
    input wire logic [2:0] req_addr,
    output logic [15:0] rsp_data,
    output logic rsp_valid,
    // Device side
    output logic [2:0] host_addr,
    output logic host_rd,
    input wire logic [15:0] host_rdata
);
    logic pend_q;
    always_ff @(posedge core_clk) begin
        host_rd <= req && !rst;
        host_addr <= req ? req_addr : ~host_addr;
        pend_q <= host_rd && !rst;
        rsp_valid <= pend_q;
        if (rst)
            host_addr <= 3'h7;
        if (pend_q)
            rsp_data <= host_rdata;
    end
endmodule : pife_host_model
`default_nettype wire

// File: testbench/pife_top_bench.sv
/* Self-checking bench for pife_top through the host read port.
   Assumes pife_host_model answers each read request. */
`timescale 1ns/1ps
`default_nettype none
module pife_top_bench;
    import pife_pkg::*;
    logic core_clk, rst, link_enable, req, host_rd, rsp_valid;
    logic [PIX_W-1:0] horiz_pixels, vert_pixels;
    logic [PIX_W-1:0] horiz_pixel_mask, vert_pixel_mask;
    logic [2:0] req_addr, host_addr;
    logic [15:0] host_rdata, rsp_data, t;
    logic [31:0] w, c_a, c_b;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int cyc_a, cyc_b, n;
    pife_host_model i_host (.core_clk(core_clk), .rst(rst), .req(req),
        .req_addr(req_addr), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .host_addr(host_addr), .host_rd(host_rd), .host_rdata(host_rdata));
    pife_top i_dut (.core_clk(core_clk), .rst(rst),
        .horiz_pixels(horiz_pixels), .vert_pixels(vert_pixels),
        .horiz_pixel_mask(horiz_pixel_mask),
        .vert_pixel_mask(vert_pixel_mask), .link_enable(link_enable),
        .host_addr(host_addr), .host_rd(host_rd), .host_rdata(host_rdata));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        int k;
        k = 0;
        req <= 1'b1;
        req_addr <= a;
        @(posedge core_clk);
        req <= 1'b0;
        do begin
            @(negedge core_clk);
            k++;
        end while (rsp_valid !== 1'b1 && k < 8);
        if (rsp_valid !== 1'b1) begin
            err_total++;
            end_sim();
        end
        d = rsp_data;
        @(posedge core_clk);
    endtask : rd
    // Tag read fetches an entry, then both data words
    task automatic ent(input logic [2:0] b, output logic [15:0] tg,
        output logic [31:0] d);
        logic [15:0] u, l;
        rd(b, tg);
        rd(b + 3'h1, u);
        rd(b + 3'h2, l);
        d = {u, l};
    endtask : ent
    task automatic pulse(input logic [PIX_W-1:0] h, output int c);
        c = cyc;
        horiz_pixels <= h;
        repeat (5) @(posedge core_clk);
        horiz_pixels <= '0;
        repeat (20) @(posedge core_clk);
    endtask : pulse
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        link_enable = 1'b0;
        req = 1'b0;
        req_addr = 3'h0;
        horiz_pixels = '0;
        vert_pixels = '0;
        horiz_pixel_mask = '0;
        vert_pixel_mask = '0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        ent(ADDR_HORIZ_TAG, t, w);
        check(t, 16'h4000);
        check(w, 32'h0000_0000);
        for (int a = 6; a < 8; a++) begin
            rd(a[2:0], t);
            check(t, 16'h0000);
        end
        // Independent slice: quads 0 and 2, stuck pixel in quad 1
        horiz_pixel_mask <= 128'h100_0000_0000;
        pulse(128'h20_0000_0100_0000_0001, cyc_a);
        ent(ADDR_HORIZ_TAG, t, w);
        check(t, 16'h0001);
        check(w, 32'h0000_0001);
        ent(ADDR_HORIZ_TAG, t, w);
        check(t, 16'h0040);
        check(w, 32'h0000_0020);
        ent(ADDR_HORIZ_TAG, t, c_a);
        check(t, 16'h8000);
        rd(ADDR_VERT_TAG, t);
        check(t, 16'h4000);
        // Linked slice seen by the horizontal channel only
        while ((cyc - cyc_a) % 5 != 0) @(posedge core_clk);
        link_enable <= 1'b1;
        pulse(128'h8000_0000_0000_0000_0000_0000_0000_0000, cyc_b);
        ent(ADDR_HORIZ_TAG, t, w);
        check(t, 16'h0061);
        check(w, 32'h8000_0000);
        ent(ADDR_HORIZ_TAG, t, c_b);
        check(t, 16'h8000);
        check(c_b - c_a, (cyc_b - cyc_a) / 5);
        ent(ADDR_VERT_TAG, t, w);
        check(t, 16'h2061);
        check(w, 32'h0000_0000);
        ent(ADDR_VERT_TAG, t, w);
        check(t, 16'h8000);
        check(w, c_b);
        // Overload: solid slices until the FIFO nears full
        link_enable <= 1'b0;
        horiz_pixels <= '1;
        repeat (60) @(posedge core_clk);
        n = 0;
        do begin
            ent(ADDR_HORIZ_TAG, t, c_a);
            n++;
        end while (t[15:14] === 2'b00 && n < 24);
        check(t, 16'h8000);
        check((n - 1) % 4, 0);
        n = 0;
        do begin
            ent(ADDR_HORIZ_TAG, t, w);
            n++;
        end while (t === 16'h4000 && n < 30);
        check(t, 16'h8001);
        check(w > c_a, 1);
        horiz_pixels <= '0;
        repeat (20) @(posedge core_clk);
        n = 0;
        do begin
            rd(ADDR_HORIZ_TAG, t);
            n++;
        end while (t !== 16'h4000 && n < 40);
        check(t, 16'h4000);
        end_sim();
    end
endmodule : pife_top_bench
`default_nettype wire
